/* verilog/tcb_pkg.sv */
// Package with offsets, field positions and reset values of the command and buffer event registers.
package tcb_pkg;
    localparam logic [8:0]  OFS_CMD_RB   = 9'h108;
    localparam logic [8:0]  OFS_ENABLES  = 9'h10A;
    localparam logic [8:0]  OFS_EVENTS   = 9'h12C;
    localparam logic [8:0]  OFS_MISS     = 9'h130;
    localparam logic [8:0]  OFS_COLL     = 9'h132;
    localparam logic [8:0]  OFS_CMD_WR   = 9'h144;
    localparam logic [5:0]  ID_CMD       = 6'h09;
    localparam logic [5:0]  ID_ENABLES   = 6'h0B;
    localparam logic [5:0]  ID_EVENTS    = 6'h0C;
    localparam logic [5:0]  ID_MISS      = 6'h10;
    localparam logic [5:0]  ID_COLL      = 6'h12;
    localparam logic [15:0] RST_CMD      = 16'h0009;
    localparam logic [15:0] RST_ENABLES  = 16'h000B;
    // Command fields.
    localparam int CMD_THR_LO  = 6;
    localparam int CMD_PURGE   = 8;
    localparam int CMD_ONECOLL = 9;
    localparam int CMD_NOFCS   = 12;
    localparam int CMD_NOPAD   = 13;
    // Enable and event bit positions.
    localparam int EV_SWIRQ   = 6;
    localparam int EV_DMA     = 7;
    localparam int EV_TXRDY   = 8;
    localparam int EV_UNDER   = 9;
    localparam int EV_LOST    = 10;
    localparam int EV_EARLY   = 11;
    localparam int EN_COLWARN = 12;
    localparam int EN_MISWARN = 13;
    localparam int EV_ADDR    = 15;
    localparam logic [15:0] CMD_STORE_MASK = 16'h33C0;
    localparam logic [15:0] EN_STORE_MASK  = 16'hBF80;
    localparam logic [15:0] EV_MASK        = 16'h8FC0;
    // Byte counts, collision limit and tally values.
    localparam logic [10:0] THR_BYTES_0 = 11'd5;
    localparam logic [10:0] THR_BYTES_1 = 11'd381;
    localparam logic [10:0] THR_BYTES_2 = 11'd1021;
    localparam logic [10:0] MIN_TX_LEN  = 11'd3;
    localparam logic [10:0] PAD_LEN     = 11'd60;
    localparam logic [4:0]  MAX_COLL    = 5'd16;
    localparam logic [9:0]  WARN_FROM   = 10'h1FF;
    localparam logic [9:0]  TALLY_MAX   = 10'h3FF;
    typedef enum logic [1:0] {TX_IDLE, TX_ARMED, TX_SENDING} tcb_tx_e;
endpackage : tcb_pkg

/* verilog/tcb_tx_cmd_buf_events.sv */
// Transmit command, buffer event and missed-frame registers with the transmit control around them.
`timescale 1ns/1ps
module tcb_tx_cmd_buf_events
    import tcb_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    input  wire logic [8:0]  regAddr,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    input  wire logic [15:0] regWrData,
    output logic      [15:0] regRdData,
    input  wire logic        eepromLoad,
    input  wire logic [15:0] eepromCmd,
    input  wire logic [15:0] eepromEnables,
    input  wire logic [10:0] transmitLength,
    input  wire logic [10:0] bytesBuffered,
    input  wire logic        frameBuffered,
    input  wire logic        txDone,
    input  wire logic        txCollision,
    input  wire logic        underrun_flag,
    input  wire logic        txReady,
    input  wire logic        dmaFrameDone,
    input  wire logic        rxLost,
    input  wire logic        rxAddrMatch,
    input  wire logic        rxByte128,
    output logic             tx_start_threshold,
    output logic             txPurge,
    output logic             txAbortBadCrc,
    output logic             txGiveUp,
    output logic             txRefuse,
    output logic             appendFcs,
    output logic             padToMin,
    output logic             hostIrq
);
    // ------------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------------
    logic [15:0] cmd_ff;
    logic [15:0] enables_ff;
    logic [15:0] events_ff;
    logic [9:0]  missTally_ff;
    logic [9:0]  collTally_ff;
    logic        missWarn_ff;
    logic        collWarn_ff;
    logic [15:0] regRdData_ff;
    logic        irq_ff;
    tcb_tx_e     txState_ff;
    logic [4:0]  collCount_ff;
    logic        tx_start_threshold_ff;
    logic        txPurge_ff;
    logic        txAbort_ff;
    logic        txGiveUp_ff;
    logic        txRefuse_ff;
    logic        appendFcs_ff;
    logic        padToMin_ff;

    logic wrCmd;
    logic wrEn;
    logic rdEvt;
    logic rdMiss;
    logic rdColl;
    logic swReq;
    logic sending;
    logic collIn;
    logic missInc;
    logic thrReached;

    function automatic logic hit(input logic en, input logic [8:0] a, input logic [8:0] ofs);
        hit = clkEn && en && (a == ofs);
    endfunction : hit

    assign wrCmd   = hit(regWrEn, regAddr, OFS_CMD_WR);
    assign wrEn    = hit(regWrEn, regAddr, OFS_ENABLES);
    assign rdEvt   = hit(regRdEn, regAddr, OFS_EVENTS);
    assign rdMiss  = hit(regRdEn, regAddr, OFS_MISS);
    assign rdColl  = hit(regRdEn, regAddr, OFS_COLL);
    assign swReq   = wrEn && regWrData[EV_SWIRQ];
    assign sending = txState_ff == TX_SENDING;
    assign collIn  = sending && txCollision;
    assign missInc = rxLost;

    // ------------------------------------------------------------------
    // Command and enable registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cmd_ff     <= RST_CMD & CMD_STORE_MASK;
            enables_ff <= RST_ENABLES & EN_STORE_MASK;
        end else if (clkEn) begin
            if (eepromLoad) begin
                cmd_ff     <= eepromCmd & CMD_STORE_MASK;
                enables_ff <= eepromEnables & EN_STORE_MASK;
            end else begin
                if (wrCmd) begin
                    cmd_ff <= regWrData & CMD_STORE_MASK;
                end
                if (wrEn) begin
                    enables_ff <= regWrData & EN_STORE_MASK;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Buffer events, cleared on read with sets winning
    // ------------------------------------------------------------------
    logic [15:0] evSet;
    always_comb begin
        evSet = '0;
        evSet[EV_SWIRQ] = swReq;
        evSet[EV_DMA]   = dmaFrameDone;
        evSet[EV_TXRDY] = txReady;
        evSet[EV_UNDER] = underrun_flag;
        evSet[EV_LOST]  = rxLost;
        evSet[EV_EARLY] = rxByte128;
        evSet[EV_ADDR]  = rxAddrMatch && !rxByte128;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            events_ff <= '0;
        end else if (clkEn) begin
            events_ff <= ((rdEvt ? '0 : events_ff) | evSet) & EV_MASK;
            if (rxByte128) begin
                events_ff[EV_ADDR] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Tallies with half-way warnings
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            missTally_ff <= '0;
            missWarn_ff  <= 1'b0;
        end else if (clkEn) begin
            missTally_ff <= (rdMiss ? '0 : missTally_ff) + 10'(missInc);
            if (missInc && !rdMiss && missTally_ff == WARN_FROM) begin
                missWarn_ff <= 1'b1;
            end else if (rdMiss) begin
                missWarn_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            collTally_ff <= '0;
            collWarn_ff  <= 1'b0;
        end else if (clkEn) begin
            collTally_ff <= (rdColl ? '0 : collTally_ff) + 10'(collIn);
            if (collIn && !rdColl && collTally_ff == WARN_FROM) begin
                collWarn_ff <= 1'b1;
            end else if (rdColl) begin
                collWarn_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------------
    logic nxt_irq;
    assign nxt_irq = (|(events_ff & enables_ff)) || events_ff[EV_SWIRQ]
                   || (missWarn_ff && enables_ff[EN_MISWARN])
                   || (collWarn_ff && enables_ff[EN_COLWARN]);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_ff <= 1'b0;
        end else if (clkEn) begin
            irq_ff <= nxt_irq;
        end
    end

    // ------------------------------------------------------------------
    // Read data with fixed identifiers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            regRdData_ff <= '0;
        end else if (clkEn && regRdEn) begin
            case (regAddr)
                OFS_CMD_RB:  regRdData_ff <= cmd_ff | 16'(ID_CMD);
                OFS_ENABLES: regRdData_ff <= enables_ff | 16'(ID_ENABLES);
                OFS_EVENTS:  regRdData_ff <= events_ff | 16'(ID_EVENTS);
                OFS_MISS:    regRdData_ff <= {missTally_ff, ID_MISS};
                OFS_COLL:    regRdData_ff <= {collTally_ff, ID_COLL};
                default:     regRdData_ff <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Transmit control
    // ------------------------------------------------------------------
    always_comb begin
        case (cmd_ff[CMD_THR_LO +: 2])
            2'b00:   thrReached = bytesBuffered >= THR_BYTES_0;
            2'b01:   thrReached = bytesBuffered >= THR_BYTES_1;
            2'b10:   thrReached = bytesBuffered >= THR_BYTES_2;
            default: thrReached = frameBuffered;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            txState_ff   <= TX_IDLE;
            collCount_ff <= '0;
            tx_start_threshold_ff   <= 1'b0;
            txPurge_ff   <= 1'b0;
            txAbort_ff   <= 1'b0;
            txGiveUp_ff  <= 1'b0;
            txRefuse_ff  <= 1'b0;
        end else if (clkEn) begin
            tx_start_threshold_ff  <= 1'b0;
            txPurge_ff  <= 1'b0;
            txAbort_ff  <= 1'b0;
            txGiveUp_ff <= 1'b0;
            txRefuse_ff <= 1'b0;
            if (wrCmd) begin
                txPurge_ff   <= regWrData[CMD_PURGE];
                txAbort_ff   <= regWrData[CMD_PURGE] && sending;
                collCount_ff <= '0;
                if (transmitLength < MIN_TX_LEN) begin
                    txRefuse_ff <= 1'b1;
                    txState_ff  <= TX_IDLE;
                end else if (regWrData[CMD_PURGE] || !sending) begin
                    txState_ff <= TX_ARMED;
                end
            end else begin
                case (txState_ff)
                    TX_IDLE: begin
                        txState_ff <= TX_IDLE;
                    end
                    TX_ARMED: begin
                        if (thrReached) begin
                            tx_start_threshold_ff <= 1'b1;
                            txState_ff <= TX_SENDING;
                        end
                    end
                    TX_SENDING: begin
                        if (underrun_flag || txDone) begin
                            txState_ff <= TX_IDLE;
                        end else if (txCollision) begin
                            if (cmd_ff[CMD_ONECOLL] || collCount_ff == MAX_COLL - 5'd1) begin
                                txGiveUp_ff <= 1'b1;
                                txState_ff  <= TX_IDLE;
                            end else begin
                                collCount_ff <= collCount_ff + 5'd1;
                            end
                        end
                    end
                    default: txState_ff <= TX_IDLE;
                endcase
            end
        end
    end

    // Framing options are latched at the start so a later command cannot change a live frame.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            appendFcs_ff <= 1'b1;
            padToMin_ff  <= 1'b0;
        end else if (clkEn && txState_ff == TX_ARMED && thrReached && !wrCmd) begin
            appendFcs_ff <= !cmd_ff[CMD_NOFCS];
            padToMin_ff  <= !cmd_ff[CMD_NOPAD] && transmitLength < PAD_LEN;
        end
    end

    assign regRdData     = regRdData_ff;
    assign hostIrq       = irq_ff;
    assign tx_start_threshold       = tx_start_threshold_ff;
    assign txPurge       = txPurge_ff;
    assign txAbortBadCrc = txAbort_ff;
    assign txGiveUp      = txGiveUp_ff;
    assign txRefuse      = txRefuse_ff;
    assign appendFcs     = appendFcs_ff;
    assign padToMin      = padToMin_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    purge_abort_a: assert property (wrCmd && regWrData[CMD_PURGE] && sending
        |=> txAbortBadCrc && txPurge) else $error("purge did not abort live frame");
    short_refuse_a: assert property (wrCmd && transmitLength < MIN_TX_LEN
        |=> txRefuse && txState_ff == TX_IDLE) else $error("short frame not refused");
    event_clear_a: assert property (rdEvt && evSet == '0 && !swReq
        |=> events_ff == '0) else $error("event read did not clear");
    sw_irq_a: assert property (swReq
        |=> events_ff[EV_SWIRQ]) else $error("software irq lost");
    irq_level_a: assert property (clkEn && (|(events_ff & enables_ff)
        || events_ff[EV_SWIRQ]) |=> hostIrq) else $error("enabled event without irq");
    miss_wrap_a: assert property (clkEn && missInc && !rdMiss && missTally_ff == TALLY_MAX
        |=> missTally_ff == '0) else $error("miss tally did not wrap");
    miss_warn_a: assert property (clkEn && missInc && !rdMiss && missTally_ff == WARN_FROM
        && enables_ff[EN_MISWARN] && !eepromLoad && !wrEn ##1 clkEn |=> hostIrq)
        else $error("miss half-way warning missing");
    coll_warn_a: assert property (clkEn && collIn && !rdColl && collTally_ff == WARN_FROM
        && enables_ff[EN_COLWARN] && !eepromLoad && !wrEn ##1 clkEn |=> hostIrq)
        else $error("collision half-way warning missing");
    one_coll_a: assert property (clkEn && collIn && !wrCmd && !txDone && !underrun_flag
        && cmd_ff[CMD_ONECOLL] |=> txGiveUp) else $error("one-collision abort missing");
    start_thr_a: assert property (clkEn && txState_ff == TX_ARMED && !wrCmd
        && cmd_ff[CMD_THR_LO +: 2] == 2'b00 && bytesBuffered >= THR_BYTES_0
        |=> tx_start_threshold && appendFcs == !$past(cmd_ff[CMD_NOFCS])) else $error("start late");
endmodule : tcb_tx_cmd_buf_events

/* dv/tcb_host_model.sv */
// Host processor model that issues word accesses to the register group.
`timescale 1ns/1ps
module tcb_host_model (
    input  wire logic        clk_sys,
    input  wire logic [15:0] regRdData,
    output logic      [8:0]  regAddr,
    output logic             regWrEn,
    output logic             regRdEn,
    output logic      [15:0] regWrData
);
    initial begin
        regAddr   = '0;
        regWrEn   = 1'b0;
        regRdEn   = 1'b0;
        regWrData = '0;
    end

    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regAddr   <= a;
        regWrData <= d;
        regWrEn   <= 1'b1;
        @(posedge clk_sys);
        regWrEn   <= 1'b0;
        regWrData <= ~d;
    endtask : wr

    task automatic rd(input logic [8:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        @(posedge clk_sys);
        d = regRdData;
    endtask : rd

    // A new command, also a restart after an underrun, goes to the write location.
    task automatic issue_cmd(input logic [15:0] d);
        wr(9'h144, d);
    endtask : issue_cmd

    // Every read of the event word is taken as handled in full.
    task automatic take_events(output logic [15:0] d);
        rd(9'h12C, d);
    endtask : take_events
endmodule : tcb_host_model

/* dv/tb_top.sv */
// Self-checking bench for the transmit command and buffer event registers.
`timescale 1ns/1ps
module tb_top;
    import tcb_pkg::*;
    logic        clk_sys = 1'b0;
    logic        sysRst  = 1'b1;
    logic        clkEn   = 1'b1;
    logic        eepLoad = 1'b0;
    logic [15:0] eepCmd  = 16'h00C0;
    logic [15:0] eepEn   = 16'h0100;
    logic [10:0] txLen   = 11'd40;
    logic [10:0] bytes   = '0;
    logic        frame   = 1'b0;
    logic [7:0]  macEv   = '0;
    logic [8:0]  regAddr;
    logic        regWrEn;
    logic        regRdEn;
    logic [15:0] regWrData;
    logic [15:0] regRdData;
    logic [15:0] rdVal;
    logic        tx_start_threshold;
    logic        txPurge;
    logic        txAbortBadCrc;
    logic        txGiveUp;
    logic        txRefuse;
    logic        appendFcs;
    logic        padToMin;
    logic        hostIrq;
    int          nStart, nPurge, nAbort, nGiveUp, nRefuse, errorCnt, nChecks;
    int          evIdx[6] = '{2, 3, 4, 5, 7, 6};
    int          evBit[6] = '{9, 8, 7, 10, 11, 15};
    logic [10:0] thr[3]   = '{11'd5, 11'd381, 11'd1021};

    always #2.5 clk_sys = ~clk_sys;

    tcb_host_model host (.clk_sys(clk_sys), .regRdData(regRdData), .regAddr(regAddr),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData));

    tcb_tx_cmd_buf_events dut (.clk_sys(clk_sys), .sys_rst(sysRst), .clkEn(clkEn),
        .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
        .regRdData(regRdData), .eepromLoad(eepLoad), .eepromCmd(eepCmd),
        .eepromEnables(eepEn), .transmitLength(txLen), .bytesBuffered(bytes),
        .frameBuffered(frame), .txDone(macEv[0]), .txCollision(macEv[1]),
        .underrun_flag(macEv[2]), .txReady(macEv[3]), .dmaFrameDone(macEv[4]),
        .rxLost(macEv[5]), .rxAddrMatch(macEv[6]), .rxByte128(macEv[7]),
        .tx_start_threshold(tx_start_threshold), .txPurge(txPurge), .txAbortBadCrc(txAbortBadCrc),
        .txGiveUp(txGiveUp), .txRefuse(txRefuse), .appendFcs(appendFcs),
        .padToMin(padToMin), .hostIrq(hostIrq));

    always @(posedge clk_sys) begin
        if (tx_start_threshold === 1'b1) nStart <= nStart + 1;
        if (txPurge === 1'b1) nPurge <= nPurge + 1;
        if (txAbortBadCrc === 1'b1) nAbort <= nAbort + 1;
        if (txGiveUp === 1'b1) nGiveUp <= nGiveUp + 1;
        if (txRefuse === 1'b1) nRefuse <= nRefuse + 1;
    end

    task automatic chk16(string n, logic [15:0] e, logic [15:0] s);
        nChecks++;
        if (s !== e) begin
            errorCnt++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : chk16

    task automatic chk1(string n, logic e, logic s);
        nChecks++;
        if (s !== e) begin
            errorCnt++;
            $display("BAD %s exp %b got %b", n, e, s);
        end
    endtask : chk1

    task automatic chkN(string n, int e, int s);
        nChecks++;
        if (s != e) begin
            errorCnt++;
            $display("BAD %s exp %0d got %0d", n, e, s);
        end
    endtask : chkN

    task automatic rchk(string n, logic [8:0] a, logic [15:0] e);
        host.rd(a, rdVal);
        chk16(n, e, rdVal);
    endtask : rchk

    task automatic pulse(input int i);
        @(posedge clk_sys);
        macEv[i] <= 1'b1;
        @(posedge clk_sys);
        macEv <= '0;
    endtask : pulse

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : idle

    task automatic wrap_up;
        $display("checks %0d errors %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (100000) @(posedge clk_sys);
        errorCnt++;
        wrap_up();
    end

    initial begin
        logic [15:0] cmd;
        int          k;
        int          j;
        repeat (5) @(posedge clk_sys);
        sysRst <= 1'b0;
        rchk("cmd", OFS_CMD_RB, RST_CMD);
        rchk("en", OFS_ENABLES, RST_ENABLES);
        rchk("ev", OFS_EVENTS, 16'h000C);
        rchk("miss", OFS_MISS, 16'h0010);
        rchk("coll", OFS_COLL, 16'h0012);
        rchk("unmapped", 9'h100, 16'h0000);
        host.wr(OFS_CMD_RB, 16'hFFFF);
        rchk("cmd ro", OFS_CMD_RB, RST_CMD);
        rchk("cmd wo", OFS_CMD_WR, 16'h0000);
        @(posedge clk_sys) eepLoad <= 1'b1;
        @(posedge clk_sys) eepLoad <= 1'b0;
        rchk("cmd eep", OFS_CMD_RB, 16'h00C9);
        rchk("en eep", OFS_ENABLES, 16'h010B);
        for (int i = 0; i < 4; i++) begin
            cmd = {2'b00, i[1], i[0], 4'h0, i[1:0], 6'h00};
            host.issue_cmd(cmd);
            rchk("cmd rb", OFS_CMD_RB, cmd | RST_CMD);
            k = nStart;
            if (i < 3) bytes <= thr[i] - 11'd1;
            else bytes <= 11'h7FF;
            idle(4);
            chkN("early start", k, nStart);
            if (i < 3) bytes <= thr[i];
            else frame <= 1'b1;
            idle(4);
            chkN("start", k + 1, nStart);
            chk1("fcs", !i[0], appendFcs);
            chk1("pad", !i[1], padToMin);
            pulse(0);
            bytes <= '0;
            frame <= 1'b0;
        end
        txLen <= 11'd2;
        bytes <= 11'd5;
        k = nStart;
        j = nRefuse;
        host.issue_cmd(16'h0000);
        idle(4);
        chkN("refuse", j + 1, nRefuse);
        chkN("no start", k, nStart);
        txLen <= 11'd40;
        j = nGiveUp;
        host.issue_cmd(16'h0200);
        idle(3);
        chk1("pad short", 1'b1, padToMin);
        pulse(1);
        idle(3);
        chkN("one coll", j + 1, nGiveUp);
        rchk("coll tally", OFS_COLL, 16'h0052);
        txLen <= 11'd60;
        host.issue_cmd(16'h0000);
        idle(3);
        chk1("pad long", 1'b0, padToMin);
        repeat (15) pulse(1);
        idle(3);
        chkN("15 coll", j + 1, nGiveUp);
        pulse(1);
        idle(3);
        chkN("16 coll", j + 2, nGiveUp);
        rchk("coll tally", OFS_COLL, 16'h0412);
        bytes <= 11'd0;
        j = nAbort;
        k = nPurge;
        host.issue_cmd(16'h0100);
        idle(3);
        chkN("purge", k + 1, nPurge);
        chkN("no abort", j, nAbort);
        bytes <= 11'd5;
        idle(3);
        bytes <= 11'd0;
        host.issue_cmd(16'h0100);
        idle(3);
        chkN("abort", j + 1, nAbort);
        bytes <= 11'd5;
        idle(3);
        host.rd(OFS_COLL, rdVal);
        pulse(2);
        pulse(1);
        rchk("underrun stop", OFS_COLL, 16'h0012);
        bytes <= 11'd0;
        pulse(0);
        // Receive DMA is never set up here, so early receive may stay enabled.
        host.wr(OFS_ENABLES, 16'hBF80);
        host.take_events(rdVal);
        for (int i = 0; i < 6; i++) begin
            pulse(evIdx[i]);
            idle(2);
            chk1("irq set", 1'b1, hostIrq);
            rchk("event", OFS_EVENTS, (16'h0001 << evBit[i]) | 16'h000C);
            idle(2);
            chk1("irq clr", 1'b0, hostIrq);
        end
        pulse(6);
        pulse(7);
        rchk("addr to early", OFS_EVENTS, 16'h080C);
        host.wr(OFS_ENABLES, 16'h2000);
        pulse(5);
        idle(2);
        chk1("irq masked", 1'b0, hostIrq);
        rchk("lost", OFS_EVENTS, 16'h040C);
        host.wr(OFS_ENABLES, 16'h2040);
        idle(2);
        chk1("sw irq", 1'b1, hostIrq);
        rchk("en once", OFS_ENABLES, 16'h200B);
        rchk("sw ev", OFS_EVENTS, 16'h004C);
        rchk("ev clr", OFS_EVENTS, 16'h000C);
        clkEn <= 1'b0;
        pulse(3);
        clkEn <= 1'b1;
        rchk("frozen", OFS_EVENTS, 16'h000C);
        host.rd(OFS_MISS, rdVal);
        repeat (3) pulse(5);
        rchk("miss", OFS_MISS, 16'h00D0);
        rchk("miss clr", OFS_MISS, 16'h0010);
        repeat (511) pulse(5);
        idle(2);
        chk1("warn early", 1'b0, hostIrq);
        pulse(5);
        idle(2);
        chk1("warn", 1'b1, hostIrq);
        rchk("miss 200", OFS_MISS, 16'h8010);
        idle(2);
        chk1("warn clr", 1'b0, hostIrq);
        wrap_up();
    end
endmodule : tb_top
